// ==== logic/sadc_pkg.sv ====
// Package of constants and types for the converter strobe interface
`default_nettype none
package sadc_pkg;
   localparam int SADC_RES_W = 13;
   localparam int SADC_BITS = 13;
   // Conversion clock divider: 20 MHz down to 1 MHz
   localparam logic [4:0] SADC_CLK_DIV = 5'h13;
   // Periods spent sampling; minus sample comes three periods after plus
   localparam logic [3:0] SADC_SAMPLE_GAP = 4'h4;
   // Periods spent updating output latches
   localparam logic [3:0] SADC_UPD_LEN = 4'h2;
   localparam logic [3:0] SADC_BIT_TOP = 4'hC;
   localparam logic [12:0] SADC_RESULT_RST = 13'h0000;

   typedef enum logic [4:0] {
      SADC_IDLE = 5'b00001,
      SADC_SAMP = 5'b00010,
      SADC_CONV = 5'b00100,
      SADC_UPD = 5'b01000,
      SADC_DONE = 5'b10000
   } sadc_state_t;

   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } sadc_strobe_t;
endpackage
`default_nettype wire

// ==== logic/sadc_clkdiv.sv ====
// Conversion clock enable divider
`default_nettype none
module sadc_clkdiv
   import sadc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Enable
   input wire logic run,
   output logic tick
);
   logic [4:0] cnt;
   wire at_top = (cnt == SADC_CLK_DIV);

   assign tick = run & at_top;

   always_ff @(posedge sys_clk) begin
      if (rst || !run || at_top) begin
         cnt <= 5'h00;
      end else begin
         cnt <= cnt + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ==== logic/sadc_core.sv ====
// Strobe control and successive approximation sequencer
`default_nettype none
module sadc_core
   import sadc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Host strobes, active low
   input wire sadc_strobe_t strobe,
   // Variant select: high for byte-wide readout
   input wire logic byte_mode,
   // Comparator: high when input above trial level
   input wire logic comp_above,
   output logic sample_plus,
   output logic sample_minus,
   output logic comp_strobe,
   output logic [SADC_RES_W-1:0] trial_code,
   // Results
   output logic [SADC_RES_W-1:0] result_word,
   output logic [7:0] byte_data_lines,
   output logic data_oe,
   output logic byte_sel_low,
   output logic conversion_done_flag_n,
   output logic wait_n,
   output logic busy
);
   sadc_state_t state;
   sadc_state_t next_state;
   logic wr_prev;
   logic rd_prev;
   logic [3:0] cnt;
   logic [3:0] bit_idx;
   logic [SADC_RES_W-1:0] sar;
   logic [SADC_RES_W-1:0] latch;
   logic tick;

   wire sel = ~strobe.cs_n;
   wire wr_fall = sel & ~strobe.wr_n & wr_prev;
   wire rd_fall = sel & ~strobe.rd_n & rd_prev;
   wire rd_rise = sel & strobe.rd_n & ~rd_prev;
   wire wr_low = sel & ~strobe.wr_n;
   wire conv_end = (state == SADC_UPD) & tick & (cnt == SADC_UPD_LEN - 4'h1);
   wire conv_step = (state == SADC_CONV) & tick;
   wire [SADC_RES_W-1:0] bit_mask = SADC_RES_W'(1) << bit_idx;
   // Once the sign is decided, trial sign is in offset form
   wire [SADC_RES_W-1:0] sign_flip = {(bit_idx != SADC_BIT_TOP), 12'h000};

   sadc_clkdiv u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(state != SADC_IDLE && state != SADC_DONE),
      .tick(tick)
   );

   // Sign bit inverted in trial so sign decides first
   assign trial_code = (sar ^ sign_flip) | bit_mask;
   assign sample_plus = (state == SADC_SAMP) & tick & (cnt == 4'h0);
   assign sample_minus = (state == SADC_SAMP) & tick & (cnt == SADC_SAMPLE_GAP - 4'h1);
   assign comp_strobe = conv_step;
   assign wait_n = (state != SADC_UPD);
   assign busy = (state != SADC_IDLE) & (state != SADC_DONE);
   assign data_oe = sel & ~strobe.rd_n;
   assign result_word = latch;

   always_comb begin
      next_state = state;
      case (state)
         SADC_IDLE, SADC_DONE: begin
            if (wr_fall) next_state = SADC_SAMP;
         end
         SADC_SAMP: begin
            if (tick && cnt == SADC_SAMPLE_GAP - 4'h1) next_state = SADC_CONV;
         end
         SADC_CONV: begin
            if (tick && bit_idx == 4'h0) next_state = SADC_UPD;
         end
         SADC_UPD: begin
            if (conv_end) next_state = SADC_DONE;
         end
         default: next_state = SADC_IDLE;
      endcase
      // Restart of a running conversion by a new strobe
      if (wr_fall && state != SADC_IDLE && state != SADC_DONE) next_state = SADC_SAMP;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= SADC_IDLE;
         wr_prev <= 1'b1;
         rd_prev <= 1'b1;
      end else begin
         state <= next_state;
         wr_prev <= ~sel | strobe.wr_n;
         rd_prev <= ~sel | strobe.rd_n;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || wr_fall || next_state != state) begin
         cnt <= 4'h0;
      end else if (tick) begin
         cnt <= cnt + 4'h1;
      end
   end

   // Successive approximation, sign first
   always_ff @(posedge sys_clk) begin
      if (rst || wr_fall) begin
         sar <= SADC_RESULT_RST;
         bit_idx <= SADC_BIT_TOP;
      end else if (conv_step) begin
         if (bit_idx == SADC_BIT_TOP) begin
            sar[bit_idx] <= ~comp_above;
         end else begin
            sar[bit_idx] <= comp_above;
         end
         if (bit_idx != 4'h0) bit_idx <= bit_idx - 4'h1;
      end
   end

   // Latch updated regardless of write length
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         latch <= SADC_RESULT_RST;
      end else if (conv_end) begin
         latch <= sar;
      end
   end

   // Long write and held-low read suppress done flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         conversion_done_flag_n <= 1'b1;
      end else if (conv_end && !wr_low && !(sel && !strobe.rd_n)) begin
         conversion_done_flag_n <= 1'b0;
      end else if (wr_fall || rd_fall) begin
         conversion_done_flag_n <= 1'b1;
      end
   end

   // Byte order toggle
   always_ff @(posedge sys_clk) begin
      if (rst || conv_end) begin
         byte_sel_low <= 1'b0;
      end else if (byte_mode && rd_rise) begin
         byte_sel_low <= ~byte_sel_low;
      end
   end

   // Byte lanes: sign-extended high byte, then low byte
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         byte_data_lines <= 8'h00;
      end else if (rd_fall || (data_oe && conv_end)) begin
         if (!byte_sel_low) begin
            byte_data_lines <= {{3{latch[12]}}, latch[12:8]};
         end else begin
            byte_data_lines <= latch[7:0];
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/sadc_sva.sv ====
// Assertions on strobe and flag timing
`default_nettype none
module sadc_sva
   import sadc_pkg::*;
(
   // Clock, reset, strobes
   input wire logic sys_clk,
   input wire logic rst,
   input wire sadc_strobe_t strobe,
   // Observed outputs
   input wire logic sample_plus,
   input wire logic sample_minus,
   input wire logic comp_strobe,
   input wire logic [SADC_RES_W-1:0] result_word,
   input wire logic data_oe,
   input wire logic byte_sel_low,
   input wire logic conversion_done_flag_n,
   input wire logic wait_n,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_upd;
      $fell(wait_n) ##1 !wait_n[*8];
   endsequence
   property p_wr; $fell(strobe.wr_n) && !strobe.cs_n |=> conversion_done_flag_n; endproperty
   a_wr: assert property (p_wr) else $error("done kept on start");
   property p_rd; $fell(strobe.rd_n) && !strobe.cs_n |=> conversion_done_flag_n; endproperty
   a_rd: assert property (p_rd) else $error("done kept on read");
   property p_sup; $fell(conversion_done_flag_n) |-> $past(strobe.wr_n) && $past(strobe.rd_n);
   endproperty
   a_sup: assert property (p_sup) else $error("done with strobe low");
   property p_oe; data_oe == (!strobe.cs_n && !strobe.rd_n); endproperty
   a_oe: assert property (p_oe) else $error("output enable wrong");
   property p_gap; sample_plus |-> ##60 sample_minus; endproperty
   a_gap: assert property (p_gap) else $error("sample gap wrong");
   property p_upd; $fell(wait_n) |-> s_upd; endproperty
   a_upd: assert property (p_upd) else $error("update too short");
   property p_lat; !$stable(result_word) |-> !$past(wait_n); endproperty
   a_lat: assert property (p_lat) else $error("latch loaded outside update");
   property p_byte; $fell(conversion_done_flag_n) |-> !byte_sel_low; endproperty
   a_byte: assert property (p_byte) else $error("byte order not reset");
   property p_cmp; comp_strobe |-> ##20 (comp_strobe || sample_plus || !wait_n); endproperty
   a_cmp: assert property (p_cmp) else $error("decision while idle");
endmodule
bind sadc_core sadc_sva u_sadc_sva (.sys_clk, .rst, .strobe, .sample_plus, .sample_minus,
   .comp_strobe, .result_word, .data_oe, .byte_sel_low, .conversion_done_flag_n, .wait_n, .busy);
`default_nettype wire

// ==== tb/sadc_cmp_model.sv ====
// Comparator model answering trial levels
`default_nettype none
module sadc_cmp_model
   import sadc_pkg::*;
(
   // Trial level and signed input value
   input wire logic [SADC_RES_W-1:0] trial_code,
   input wire logic [SADC_RES_W-1:0] target,
   output logic comp_above
);
   timeunit 1ns;
   timeprecision 1ns;
   // Offset binary compare of signed input
   assign comp_above = {~target[12], target[11:0]} >= trial_code;
endmodule
`default_nettype wire

// ==== tb/sadc_core_test.sv ====
// Self-checking bench for the strobe interface
`default_nettype none
module sadc_core_test;
   import sadc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst = 1, byte_mode = 0, comp_above, sample_plus, sample_minus;
   logic comp_strobe, data_oe, byte_sel_low, conversion_done_flag_n, wait_n, busy;
   sadc_strobe_t strobe = 3'h7;
   logic [12:0] target = 13'h1A5C, trial_code, result_word;
   logic [7:0] byte_data_lines;
   int n_mismatch = 0, check_count = 0;
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
   sadc_core u_sadc_core (.sys_clk, .rst, .strobe, .byte_mode, .comp_above, .sample_plus,
      .sample_minus, .comp_strobe, .trial_code, .result_word, .byte_data_lines, .data_oe,
      .byte_sel_low, .conversion_done_flag_n, .wait_n, .busy);
   sadc_cmp_model u_sadc_cmp_model (.trial_code, .target, .comp_above);
   initial forever #25 sys_clk = ~sys_clk;
   task automatic drive(input logic [2:0] v, input int n);
      @(posedge sys_clk);
      #2 strobe = v;
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic wait_idle;
      repeat (3) @(posedge sys_clk);
      for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge sys_clk);
      #2;
   endtask
   task automatic t_tied;
      drive(3'h0, 3);
      drive(3'h3, 1);
      wait_idle;
      `CHK(conversion_done_flag_n, 1'b0)
      `CHK(result_word, target)
      drive(3'h0, 2);
      `CHK(conversion_done_flag_n, 1'b1)
      drive(3'h7, 1);
      wait_idle;
      $display("t_tied done");
   endtask
   task automatic t_long;
      target = 13'h0123;
      drive(3'h1, 600);
      `CHK(conversion_done_flag_n, 1'b1)
      `CHK(result_word, target)
      drive(3'h7, 2);
      $display("t_long done");
   endtask
   task automatic t_rdlow;
      target = 13'h1FFF;
      drive(3'h2, 2);
      drive(3'h0, 2);
      drive(3'h2, 1);
      wait_idle;
      `CHK(conversion_done_flag_n, 1'b1)
      `CHK(data_oe, 1'b1)
      `CHK(result_word, target)
      drive(3'h7, 2);
      $display("t_rdlow done");
   endtask
   task automatic t_byte;
      byte_mode = 1;
      target = 13'h1234;
      drive(3'h0, 3);
      drive(3'h3, 1);
      wait_idle;
      drive(3'h0, 3);
      `CHK(byte_data_lines, {{3{target[12]}}, target[12:8]})
      drive(3'h3, 5);
      drive(3'h0, 3);
      `CHK(byte_data_lines, target[7:0])
      drive(3'h7, 1);
      wait_idle;
      $display("t_byte done");
   endtask
   task automatic t_loop;
      logic last;
      int upd;
      last = 1'b1;
      upd = 0;
      byte_mode = 0;
      target = 13'h0ABC;
      drive(3'h1, 1);
      repeat (900) begin
         @(posedge sys_clk);
         #2 strobe.wr_n = ~wait_n;
         if (last && !wait_n) upd++;
         last = wait_n;
      end
      `CHK(upd, 2)
      `CHK(result_word, target)
      `CHK(conversion_done_flag_n, 1'b1)
      drive(3'h7, 1);
      wait_idle;
      $display("t_loop done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #300000;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      #2 rst = 0;
      t_tied;
      t_long;
      t_rdlow;
      t_byte;
      t_loop;
      wrap_up;
   end
endmodule
`default_nettype wire
